//--- design/armh_pkg.sv
// Package: constants and types for the axis resource map and homing block
package armh_pkg;

    localparam int NUM_AXES     = 6;
    localparam int NUM_ENC      = 6;
    localparam int NUM_ADC      = 8;
    localparam int NUM_DAC      = 6;
    localparam int STEP_FIRST   = 5;
    localparam int NUM_CAPT_ENC = 4;
    localparam int MAX_VS_SMALL = 3;
    localparam int MAX_VS_BIG   = 2;
    localparam int MAX_PROGS    = 10;
    localparam int MAX_PROGS_MEM = 5;
    localparam int NUM_VARS     = 120;
    localparam int PROG_MEM_KB  = 32;

    // Resource codes: type in [5:4], index (zero based) in [3:0]
    localparam logic [1:0] RT_NONE = 2'h0;
    localparam logic [1:0] RT_ENC  = 2'h1;
    localparam logic [1:0] RT_ADC  = 2'h2;
    localparam logic [1:0] RT_DAC  = 2'h1;
    localparam logic [1:0] RT_STEP = 2'h2;

    // Register offsets
    localparam logic [7:0] OFS_AXIS_BASE = 8'h00;  // 0x00..0x05 axis map
    localparam logic [7:0] OFS_MAP_ERR   = 8'h08;
    localparam logic [7:0] OFS_VSPACE    = 8'h09;
    localparam logic [7:0] OFS_GPIO_EN   = 8'h0A;
    localparam logic [7:0] OFS_GPIO_OUT  = 8'h0B;
    localparam logic [7:0] OFS_GPIO_IN   = 8'h0C;
    localparam logic [7:0] OFS_HOME_CMD  = 8'h10;
    localparam logic [7:0] OFS_HOME_ST   = 8'h11;
    localparam logic [7:0] OFS_PROG_CMD  = 8'h12;
    localparam logic [7:0] OFS_PROG_ST   = 8'h13;
    localparam logic [7:0] OFS_IDX_OFS   = 8'h14;
    localparam logic [7:0] OFS_IDX_POS   = 8'h15;
    localparam logic [7:0] OFS_AXIS_CLS  = 8'h16;

    // Axis map register fields
    localparam int F_FB1 = 0;    // [5:0]
    localparam int F_FB2 = 6;    // [11:6]
    localparam int F_OUT1 = 12;  // [17:12]
    localparam int F_OUT2 = 18;  // [23:18]
    localparam int F_CL  = 24;   // closed loop stepper
    localparam int F_VS  = 28;   // [29:28] vector space 0 = none

    // Home command fields
    localparam int H_AXIS = 0;   // [2:0]
    localparam int H_DIR  = 4;
    localparam int H_EDGE = 5;
    localparam int H_APPR = 6;
    localparam int H_ADIR = 7;
    localparam int H_IDX  = 8;
    localparam int H_GO   = 31;

    localparam logic [31:0] ONE_REV_DEFAULT = 32'h0000_0FA0;

    typedef struct packed {
        logic [5:0] fb1;
        logic [5:0] fb2;
        logic [5:0] out1;
        logic [5:0] out2;
        logic       closed_loop;
        logic [1:0] vspace;
    } armh_axis_type;

    typedef struct packed {
        logic fwd_limit;
        logic rev_limit;
        logic home;
    } armh_switch_type;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_SEEK   = 3'b001,
        HS_PAST   = 3'b010,
        HS_APPR   = 3'b011,
        HS_INDEX  = 3'b100,
        HS_RETURN = 3'b101,
        HS_DONE   = 3'b110,
        HS_FAIL   = 3'b111
    } armh_home_state_type;

endpackage : armh_pkg

//--- design/armh_top.sv
// Axis resource map, per-axis motion lines, program limits and homing sequencer
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module armh_top
    import armh_pkg::*;
#(
    parameter int NAXES = NUM_AXES
)(
    input  wire logic                  ref_clk,     // 100 MHz clock
    input  wire logic                  rst_n,       // Async reset, active low
    input  wire logic [7:0]            addr,        // Register address
    input  wire logic [31:0]           wdata,       // Write data
    input  wire logic                  wr,          // Write strobe
    input  wire logic                  rd,          // Read strobe
    output logic      [31:0]           rdata,       // Read data, cycle after rd
    input  wire armh_switch_type [5:0] sw_in,       // Limit and home lines
    output logic      [5:0]            inhibit,     // Inhibit lines
    input  wire logic [5:0]            enc_index,   // Encoder index marks
    input  wire logic [31:0]           axis_pos,    // Position of homing axis
    input  wire logic [5:0]            move_active, // Axis moving
    output logic      [5:0]            halt,        // Halt-stop request per axis
    output logic                       home_run,    // Search motion request
    output logic                       home_dir,    // Search direction, 1 = forward
    output logic      [31:0]           target_pos,  // Return target position
    output logic                       target_go,   // Target move valid
    input  wire logic                  target_done, // Target move complete
    output logic      [5:0]            capt_en,     // Capture/breakpoint enable
    output logic      [5:0]            dac_direct   // DAC free for direct use
);

    // ============================================================
    // Register file
    armh_axis_type    axis_map [NAXES];
    logic [31:0]      map_err;
    logic [17:0]      gpio_en;        // 1 = dedicated function on
    logic [5:0]       gpio_out;
    logic [9:0]       prog_run;
    logic [9:0]       prog_in_flash;
    logic [31:0]      home_cfg;
    logic [31:0]      idx_ofs;
    logic [31:0]      idx_pos;
    armh_home_state_type hstate;

    function automatic logic res_ok_fb(input logic [5:0] r);
        res_ok_fb = (r[5:4] == RT_NONE) ||
                    (r[5:4] == RT_ENC && r[3:0] < 4'(NUM_ENC)) ||
                    (r[5:4] == RT_ADC && r[3:0] < 4'(NUM_ADC));
    endfunction : res_ok_fb

    function automatic logic res_ok_out(input logic [5:0] r);
        res_ok_out = (r[5:4] == RT_NONE) ||
                     (r[5:4] == RT_DAC && r[3:0] < 4'(NUM_DAC)) ||
                     (r[5:4] == RT_STEP && r[3:0] >= 4'(STEP_FIRST - 1)
                      && r[3:0] < 4'(NUM_DAC));
    endfunction : res_ok_out

    // ============================================================
    // Map write checking
    wire         wr_axis  = wr && addr < 8'(NAXES);
    wire [2:0]   wr_ax    = addr[2:0];
    armh_axis_type new_map;
    assign new_map = '{fb1: wdata[F_FB1+:6], fb2: wdata[F_FB2+:6], out1: wdata[F_OUT1+:6],
                       out2: wdata[F_OUT2+:6], closed_loop: wdata[F_CL],
                       vspace: wdata[F_VS+:2]};

    logic clash;
    logic [2:0] vs_count [4];
    always_comb
    begin
        clash = 1'b0;
        for (int i = 0; i < 4; i++)
            vs_count[i] = 3'h0;
        for (int a = 0; a < NAXES; a++)
        begin
            armh_axis_type m;
            m = (a == int'(wr_ax)) ? new_map : axis_map[a];
            vs_count[m.vspace] = vs_count[m.vspace] + 3'h1;
            if (a != int'(wr_ax))
            begin
                // Refuse a resource held by another axis
                if (new_map.fb1[5:4] != RT_NONE &&
                    (new_map.fb1 == m.fb1 || new_map.fb1 == m.fb2))
                    clash = 1'b1;
                if (new_map.fb2[5:4] != RT_NONE &&
                    (new_map.fb2 == m.fb1 || new_map.fb2 == m.fb2))
                    clash = 1'b1;
                if (new_map.out1[5:0] != 6'h0 &&
                    (new_map.out1[3:0] == m.out1[3:0] && m.out1 != 6'h0 ||
                     new_map.out1[3:0] == m.out2[3:0] && m.out2 != 6'h0))
                    clash = 1'b1;
                if (new_map.out2[5:0] != 6'h0 &&
                    (new_map.out2[3:0] == m.out1[3:0] && m.out1 != 6'h0 ||
                     new_map.out2[3:0] == m.out2[3:0] && m.out2 != 6'h0))
                    clash = 1'b1;
            end
        end
    end

    // Vector space capacity: three of up to two axes, or two of three
    logic       vs_big1, vs_big2, vs_big3, vs_over;
    assign vs_big1 = vs_count[1] == 3'h3;
    assign vs_big2 = vs_count[2] == 3'h3;
    assign vs_big3 = vs_count[3] == 3'h3;
    assign vs_over = vs_count[1] > 3'h3 || vs_count[2] > 3'h3 || vs_count[3] > 3'h3 ||
                     (vs_big1 || vs_big2 || vs_big3) && vs_count[1] != 3'h0 &&
                     vs_count[2] != 3'h0 && vs_count[3] != 3'h0;

    // Servo and closed stepper need feedback; open stepper does not
    wire new_step  = new_map.out1[5:4] == RT_STEP;
    wire fb_needed = !new_step || new_map.closed_loop;
    wire fb_bad    = fb_needed && new_map.fb1[5:4] == RT_NONE;
    wire map_bad   = clash || vs_over || fb_bad || new_map.out1[5:4] == RT_NONE ||
                     !res_ok_fb(new_map.fb1) || !res_ok_fb(new_map.fb2) ||
                     !res_ok_out(new_map.out1) || !res_ok_out(new_map.out2);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int a = 0; a < NAXES; a++)  // Servo default, encoder n, DAC n
                axis_map[a] <= '{fb1: {RT_ENC, 4'(a)}, fb2: 6'h0,
                                 out1: {RT_DAC, 4'(a)}, out2: 6'h0,
                                 closed_loop: 1'b0, vspace: 2'h0};
            map_err <= 32'h0;
        end
        else if (wr_axis)
        begin
            if (map_bad)
                map_err <= {1'b1, 28'h0, wr_ax};  // Refused write, axis in low bits
            else
                axis_map[wr_ax] <= new_map;
        end
        else if (wr && addr == OFS_MAP_ERR)
            map_err <= 32'h0;
    end

    // ============================================================
    // Per-axis lines and halt
    logic [5:0] halt_now;
    always_comb
    begin
        for (int a = 0; a < NUM_AXES; a++)
            halt_now[a] = move_active[a] &&
                ((gpio_en[3*a] && sw_in[a].fwd_limit) ||
                 (gpio_en[3*a+1] && sw_in[a].rev_limit) ||
                 (gpio_en[3*a+2] && sw_in[a].home && hstate == HS_IDLE));
    end

    logic [5:0] dac_used;
    always_comb
    begin
        dac_used = 6'h0;
        for (int a = 0; a < NAXES; a++)
        begin
            if (axis_map[a].out1[5:4] == RT_DAC)
                dac_used[axis_map[a].out1[2:0]] = 1'b1;
            if (axis_map[a].out2[5:4] == RT_DAC)
                dac_used[axis_map[a].out2[2:0]] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_en    <= 18'h3FFFF;
            gpio_out   <= 6'h0;
            halt       <= 6'h0;
            inhibit    <= 6'h0;
            dac_direct <= 6'h0;
            capt_en    <= 6'h0;
        end
        else
        begin
            if (wr && addr == OFS_GPIO_EN)
                gpio_en <= wdata[17:0];
            if (wr && addr == OFS_GPIO_OUT)
                gpio_out <= wdata[5:0];
            halt       <= halt_now;
            inhibit    <= gpio_out;
            dac_direct <= ~dac_used;
            capt_en    <= 6'(4'hF);
        end
    end

    // ============================================================
    // Program slots: five per memory, ten total
    logic [3:0] ram_cnt, flash_cnt;
    always_comb
    begin
        ram_cnt = 4'h0;
        flash_cnt = 4'h0;
        for (int p = 0; p < MAX_PROGS; p++)
            if (prog_run[p])
            begin
                if (prog_in_flash[p])
                    flash_cnt = flash_cnt + 4'h1;
                else
                    ram_cnt = ram_cnt + 4'h1;
            end
    end
    wire [3:0] p_slot  = wdata[3:0];
    wire       p_start = wr && addr == OFS_PROG_CMD && wdata[8] && p_slot < 4'(MAX_PROGS);
    wire       p_stop  = wr && addr == OFS_PROG_CMD && !wdata[8] && p_slot < 4'(MAX_PROGS);
    wire       p_room  = wdata[9] ? flash_cnt < 4'(MAX_PROGS_MEM) : ram_cnt < 4'(MAX_PROGS_MEM);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_run      <= 10'h0;
            prog_in_flash <= 10'h0;
        end
        else if (p_start && p_room && !prog_run[p_slot])
        begin
            prog_run[p_slot]      <= 1'b1;
            prog_in_flash[p_slot] <= wdata[9];
        end
        else if (p_stop)
            prog_run[p_slot] <= 1'b0;
    end

    // ============================================================
    // Home and index sequencer
    wire [2:0] hax     = home_cfg[H_AXIS+:3];
    wire       h_home  = sw_in[hax].home;
    wire       h_limit = home_dir ? sw_in[hax].fwd_limit : sw_in[hax].rev_limit;
    wire       h_edge  = home_cfg[H_EDGE] ? h_home : !h_home;
    armh_axis_type hmap;
    assign hmap = axis_map[hax];
    wire idx_allowed = hmap.fb1[5:4] == RT_ENC &&
                       (hmap.out1[5:4] == RT_DAC || hmap.closed_loop);
    wire h_go = wr && addr == OFS_HOME_CMD && wdata[H_GO] && hstate != HS_SEEK
                && wdata[H_AXIS+:3] < 3'(NAXES);
    logic [31:0] rev_start;
    logic        seen_on;
    // Travel measured along the search direction; a move against it wraps to a large value past one turn
    wire  [31:0] rev_travel = home_dir ? axis_pos - rev_start : rev_start - axis_pos;
    armh_home_state_type next_hstate;

    always_comb
    begin
        next_hstate = hstate;
        unique case (hstate)
            HS_IDLE, HS_DONE, HS_FAIL:
                if (h_go)
                    next_hstate = wdata[H_IDX] ? HS_INDEX : HS_SEEK;
            HS_SEEK:
                if (seen_on && h_edge)
                    next_hstate = home_cfg[H_APPR] ? HS_PAST : HS_DONE;
            HS_PAST:
                if (!h_edge)
                    next_hstate = HS_APPR;
            HS_APPR:
                if (h_edge)
                    next_hstate = HS_DONE;
            HS_INDEX:
                if (!idx_allowed)
                    next_hstate = HS_FAIL;
                else if (enc_index[hmap.fb1[2:0]])
                    next_hstate = HS_RETURN;
                else if (rev_travel > ONE_REV_DEFAULT)
                    next_hstate = HS_FAIL;
            HS_RETURN:
                if (target_done)
                    next_hstate = HS_DONE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hstate     <= HS_IDLE;
            home_cfg   <= 32'h0;
            home_dir   <= 1'b0;
            rev_start  <= 32'h0;
            idx_pos    <= 32'h0;
            idx_ofs    <= 32'h0;
            seen_on    <= 1'b0;
            target_pos <= 32'h0;
        end
        else
        begin
            hstate <= next_hstate;
            if (wr && addr == OFS_IDX_OFS)
                idx_ofs <= wdata;
            if (h_go)
            begin
                home_cfg  <= wdata;
                home_dir  <= wdata[H_DIR];
                rev_start <= axis_pos;
                seen_on   <= 1'b0;
            end
            else if (hstate == HS_SEEK)
            begin
                seen_on <= seen_on | !h_edge;
                if (h_limit)
                    home_dir <= !home_dir;
            end
            else if (hstate == HS_PAST && next_hstate == HS_APPR)
                home_dir <= home_cfg[H_ADIR];
            if (hstate == HS_INDEX && next_hstate == HS_RETURN)
            begin
                idx_pos    <= axis_pos;
                target_pos <= axis_pos + idx_ofs;
            end
        end
    end

    assign home_run  = hstate == HS_SEEK || hstate == HS_PAST ||
                       hstate == HS_APPR || hstate == HS_INDEX;
    assign target_go = hstate == HS_RETURN;

    // ============================================================
    // Read mux; mapped state addressed by axis, axis class of all axes in one register
    logic [5:0] is_stepper;
    always_comb
        for (int a = 0; a < NUM_AXES; a++)
            is_stepper[a] = a < NAXES && axis_map[a].out1[5:4] == RT_STEP;

    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0;
        if (addr < 8'(NAXES))
            next_rdata = {2'h0, axis_map[addr[2:0]].vspace, 3'h0,
                          axis_map[addr[2:0]].closed_loop, axis_map[addr[2:0]].out2,
                          axis_map[addr[2:0]].out1, axis_map[addr[2:0]].fb2,
                          axis_map[addr[2:0]].fb1};
        else
            unique case (addr)
                OFS_MAP_ERR:  next_rdata = map_err;
                OFS_GPIO_EN:  next_rdata = {14'h0, gpio_en};
                OFS_GPIO_OUT: next_rdata = {26'h0, gpio_out};
                OFS_GPIO_IN:  next_rdata = {14'h0, sw_in};
                OFS_HOME_CMD: next_rdata = home_cfg;
                OFS_HOME_ST:  next_rdata = {28'h0, home_dir, hstate};
                OFS_PROG_ST:  next_rdata = {6'h0, prog_in_flash, 6'h0, prog_run};
                OFS_IDX_OFS:  next_rdata = idx_ofs;
                OFS_IDX_POS:  next_rdata = idx_pos;
                OFS_AXIS_CLS: next_rdata = {26'h0, is_stepper};
                default:      next_rdata = 32'h0;
            endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 32'h0;
        else
            rdata <= rd ? next_rdata : 32'h0;
    end

    // ============================================================
    // Checks
    a_halt_on_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        move_active[0] && gpio_en[0] && sw_in[0].fwd_limit |=> halt[0])
        else $error("halt missing on forward limit");
    a_index_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hstate == HS_INDEX && !idx_allowed |=> hstate == HS_FAIL)
        else $error("index search on illegal axis");
    a_ram_slots: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ram_cnt <= 4'(MAX_PROGS_MEM) && flash_cnt <= 4'(MAX_PROGS_MEM))
        else $error("too many programs in one memory");
    a_reject_clash: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_axis && map_bad |=> axis_map[$past(wr_ax)] == $past(axis_map[wr_ax]) && map_err[31])
        else $error("bad mapping accepted");
    a_read_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd && addr == OFS_AXIS_CLS |=> rdata == {26'h0, $past(is_stepper)})
        else $error("axis class read wrong");
    a_limit_reverse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hstate == HS_SEEK && !h_go && h_limit |=> home_dir != $past(home_dir))
        else $error("home search did not reverse");
    a_index_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hstate == HS_INDEX && next_hstate == HS_RETURN |=>
        target_pos == $past(axis_pos) + idx_ofs && target_go)
        else $error("index return target wrong");
    a_dac_direct: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 dac_direct == ~$past(dac_used))
        else $error("direct DAC flag wrong");
    c_home_done: cover property (@(posedge ref_clk) hstate == HS_APPR ##[1:100] hstate == HS_DONE);
    c_index_ok: cover property (@(posedge ref_clk) hstate == HS_RETURN ##1 hstate == HS_DONE);
    c_remap: cover property (@(posedge ref_clk) wr_axis && !map_bad);

endmodule : armh_top

//--- verif/armh_drive_model.sv
// Drive, encoder and switch model standing behind axis 0
`timescale 1ns/1ps
// ====================================================
// Drive model
module armh_drive_model
    import armh_pkg::*;
(
    input  wire logic                  ref_clk,     // Clock
    input  wire logic                  rst_n,       // Reset, active low
    input  wire logic                  home_run,    // Search request
    input  wire logic                  home_dir,    // 1 = forward
    input  wire logic                  target_go,   // Return request
    input  wire logic [31:0]           target_pos,  // Return target
    input  wire armh_switch_type [5:0] sw_force,    // Bench switch levels
    output logic      [31:0]           axis_pos,    // Axis position
    output armh_switch_type [5:0]      sw_in,       // Switch levels
    output logic      [5:0]            enc_index,   // Index marks
    output logic                       target_done  // Return reached
);
    wire signed [31:0] p;
    assign p = axis_pos;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            axis_pos <= 32'h0;
        else if (home_run)
            axis_pos <= home_dir ? axis_pos + 32'h1 : axis_pos - 32'h1;
        else if (target_go && !target_done)
            axis_pos <= ($signed(target_pos) > p) ? axis_pos + 32'h1 : axis_pos - 32'h1;
    end
    // Limit shown only while driving into it: the search flips once, not every cycle
    always_comb
    begin
        sw_in = sw_force;
        sw_in[0].rev_limit = sw_force[0].rev_limit | (p < -32'sh40 && !home_dir && home_run);
        sw_in[0].home = sw_force[0].home | (p >= 32'shC8 && p <= 32'sh104);
    end
    assign enc_index   = {5'h0, p == 32'sh12C};
    assign target_done = target_go && axis_pos == target_pos;
endmodule : armh_drive_model

//--- verif/armh_top_tb_top.sv
// Bench for the axis map, motion lines, program slots and homing
`timescale 1ns/1ps
// ====================================================
// Bench
module armh_top_tb_top;
    import armh_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] move_active = 6'h0;
    armh_switch_type [5:0] sw_force = '0;
    wire [31:0] rdata, axis_pos, target_pos;
    wire [5:0] inhibit, enc_index, halt, capt_en, dac_direct;
    wire home_run, home_dir, target_go, target_done;
    armh_switch_type [5:0] sw_in;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] v;
    logic [31:0] bad [3] = '{32'h0001_4010, 32'h0001_4000, 32'h0002_0014};
    always #5 ref_clk = ~ref_clk;
    armh_top u_armh_top (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sw_in(sw_in), .inhibit(inhibit),
        .enc_index(enc_index), .axis_pos(axis_pos), .move_active(move_active), .halt(halt),
        .home_run(home_run), .home_dir(home_dir), .target_pos(target_pos),
        .target_go(target_go), .target_done(target_done), .capt_en(capt_en),
        .dac_direct(dac_direct));
    armh_drive_model u_armh_drive_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .home_run(home_run), .home_dir(home_dir), .target_go(target_go),
        .target_pos(target_pos), .sw_force(sw_force), .axis_pos(axis_pos), .sw_in(sw_in),
        .enc_index(enc_index), .target_done(target_done));
    task automatic test_done;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Poll the search state with a bounded count
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 2000; i++)
        begin
            rd_reg(OFS_HOME_ST, v);
            if (v[2:0] === s)
                break;
        end
        chk({29'h0, v[2:0]}, {29'h0, s});
    endtask : wait_state
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
    // ====================================================
    // Scenarios
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd_reg(8'(i), v);
            chk(v & 32'h0003_F03F, 32'h0001_0010 + 32'(i) * 32'h1001);
        end
        rd_reg(OFS_AXIS_CLS, v);
        chk(v, 32'h0);
        chk({26'h0, capt_en}, 32'hF);
        chk({26'h0, dac_direct}, 32'h0);
        wr_reg(8'h05, 32'h0002_5000);
        rd_reg(OFS_AXIS_CLS, v);
        chk(v, 32'h20);
        chk({26'h0, dac_direct}, 32'h20);
        chk({26'h0, capt_en}, 32'hF);
        foreach (bad[k])
        begin
            wr_reg(OFS_MAP_ERR, 32'h0);
            wr_reg(8'h04, bad[k]);
            rd_reg(OFS_MAP_ERR, v);
            chk({31'h0, v[31]}, 32'h1);
            rd_reg(8'h04, v);
            chk(v & 32'h0003_F03F, 32'h0001_4014);
        end
        move_active <= 6'h01;
        sw_force[0].fwd_limit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({26'h0, halt}, 32'h1);
        wr_reg(OFS_GPIO_EN, 32'h0003_FFF8);
        repeat (2) @(posedge ref_clk);
        chk({26'h0, halt}, 32'h0);
        wr_reg(OFS_GPIO_OUT, 32'h2A);
        repeat (2) @(posedge ref_clk);
        chk({26'h0, inhibit}, 32'h2A);
        sw_force <= '0;
        move_active <= 6'h0;
        wr_reg(OFS_GPIO_EN, 32'h0003_FFFF);
        for (int s = 0; s < 6; s++)
            wr_reg(OFS_PROG_CMD, 32'h100 | 32'(s));
        for (int s = 5; s < 10; s++)
            wr_reg(OFS_PROG_CMD, 32'h300 | 32'(s));
        rd_reg(OFS_PROG_ST, v);
        chk(v, 32'h03E0_03FF);
        wr_reg(OFS_PROG_CMD, 32'h0);
        rd_reg(OFS_PROG_ST, v);
        chk(v, 32'h03E0_03FE);
        wr_reg(OFS_HOME_CMD, 32'h8000_0020);
        wait_state(HS_DONE);
        chk({31'h0, $signed(axis_pos) >= 32'shC8 && $signed(axis_pos) <= 32'sh104}, 32'h1);
        wr_reg(OFS_IDX_OFS, 32'h10);
        wr_reg(OFS_HOME_CMD, 32'h8000_0130);
        wait_state(HS_DONE);
        rd_reg(OFS_IDX_POS, v);
        chk(v, 32'h12C);
        chk(target_pos, 32'h13C);
        chk(axis_pos, 32'h13C);
        wr_reg(OFS_HOME_CMD, 32'h8000_0115);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, home_run, target_go}, 32'h0);
        test_done();
    end
endmodule : armh_top_tb_top
